// ===== core/gst_pkg.sv
package gst_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int GST_NUM_TMR = 3;
  localparam int GST_ADDR_W  = 8;

  // ----------------------------------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] GST_TMR_STRIDE   = 8'h10;
  localparam logic [7:0] GST_OFF_CNT_LO   = 8'h00;
  localparam logic [7:0] GST_OFF_CNT_HI   = 8'h04;
  localparam logic [7:0] GST_OFF_CTRL     = 8'h08;
  localparam logic [7:0] GST_OFF_GATE     = 8'h0c;
  localparam logic [7:0] GST_OFF_INT_STAT = 8'h30;
  localparam logic [7:0] GST_OFF_INT_MASK = 8'h34;
  localparam logic [7:0] GST_OFF_OSC_STAT = 8'h38;

  // ----------------------------------------------------------------
  // reset values and timing counts
  // ----------------------------------------------------------------
  localparam logic [7:0]  GST_CTRL_RST      = 8'h00;
  localparam logic [7:0]  GST_GATE_RST      = 8'h00;
  localparam logic [15:0] GST_CNT_RST       = 16'h0000;
  localparam logic [1:0]  GST_INT_DIV_LAST  = 2'h3;
  localparam logic [10:0] GST_OSC_STABLE    = 11'h400;
  localparam logic [1:0]  GST_RESP_OKAY     = 2'h0;
  localparam logic [1:0]  GST_RESP_SLVERR   = 2'h2;

  // ----------------------------------------------------------------
  // field layouts
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0] reserved;
    logic [1:0] prescale_select;
    logic       ext_clk_sel;
    logic       secondary_osc_enable;
    logic       sync_disable;
    logic       timer_on;
  } gst_ctrl_t;

  typedef struct packed {
    logic       gate_enable_bit;
    logic       gate_polarity_bit;
    logic [3:0] reserved;
    logic [1:0] gate_src_sel;
  } gst_gate_t;

  typedef struct packed {
    gst_ctrl_t ctrl;
    gst_gate_t gate;
  } gst_cfg_t;

  typedef struct packed {
    logic [15:0] count;
    logic        overflow;
    logic        secondary_osc_ready;
  } gst_stat_t;

endpackage

// ===== core/gst_timer.sv
`timescale 1ns/100ps
`default_nettype none

module gst_timer (
  input  wire logic           mclk,
  input  wire logic           rstn,
  input  var  gst_pkg::gst_cfg_t cfg,
  input  wire logic           wr_lo,
  input  wire logic           wr_hi,
  input  wire logic [7:0]     wr_data,
  input  wire logic           int_tick,
  input  wire logic           sleep,
  input  wire logic           count_clock,
  input  wire logic           crystal_input_pin,
  input  wire logic           gate_signal,
  input  wire logic [2:0]     gate_int_src,
  output var  gst_pkg::gst_stat_t stat,
  output logic                crystal_output_pin
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0]  sync1;
    logic [2:0]  sync2;
    logic        ext_prev;
    logic        xtal_prev;
    logic        edge_dly;
    logic [2:0]  ps;
    logic [15:0] count;
    logic        ovf;
    logic [10:0] osc_cnt;
    logic        ready;
    logic        xout;
  } gst_tmr_state_t;

  gst_tmr_state_t s;
  gst_tmr_state_t next_s;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic       ext_lvl;
    logic       ext_rise;
    logic       ext_edge;
    logic       clk_edge;
    logic       run_ok;
    logic [3:0] gate_vec;
    logic       gate_lvl;
    logic       gate_ok;
    logic [2:0] ps_mask;
    ext_lvl  = 1'b0;
    ext_rise = 1'b0;
    ext_edge = 1'b0;
    clk_edge = 1'b0;
    run_ok   = 1'b0;
    gate_vec = 4'h0;
    gate_lvl = 1'b0;
    gate_ok  = 1'b0;
    ps_mask  = 3'h0;
    next_s     = s;
    next_s.ovf = 1'b0;
    // pins pass two flops: {gate, crystal, external clock}
    next_s.sync1 = {gate_signal, crystal_input_pin, count_clock};
    next_s.sync2 = s.sync1;
    // crystal replaces the external clock pin when the oscillator runs
    ext_lvl  = cfg.ctrl.secondary_osc_enable ? s.sync2[1] : s.sync2[0];
    ext_rise = ext_lvl & ~s.ext_prev;
    next_s.ext_prev = ext_lvl;
    next_s.edge_dly = ext_rise;
    // unsynchronised path skips the phase-alignment stage
    ext_edge = cfg.ctrl.sync_disable ? ext_rise : s.edge_dly;
    clk_edge = cfg.ctrl.ext_clk_sel ? ext_edge : int_tick;
    // only the asynchronous external path runs in sleep
    run_ok   = ~sleep | (cfg.ctrl.ext_clk_sel & cfg.ctrl.sync_disable);
    gate_vec = {gate_int_src, s.sync2[2]};
    gate_lvl = gate_vec[cfg.gate.gate_src_sel];
    gate_ok  = ~cfg.gate.gate_enable_bit
             | (gate_lvl == cfg.gate.gate_polarity_bit);
    ps_mask  = (3'h1 << cfg.ctrl.prescale_select) - 3'h1;
    if (cfg.ctrl.timer_on && run_ok && gate_ok && clk_edge) begin
      next_s.ps = s.ps + 3'h1;
      if ((s.ps & ps_mask) == ps_mask) begin
        next_s.count = s.count + 16'h0001;
        next_s.ovf   = (s.count == 16'hffff);
      end
    end
    // byte writes load the count and clear the prescaler
    if (wr_lo) begin
      next_s.count[7:0] = wr_data;
      next_s.ps         = 3'h0;
    end
    if (wr_hi) begin
      next_s.count[15:8] = wr_data;
      next_s.ps          = 3'h0;
    end
    // oscillator amplifier and start-up counting
    next_s.xtal_prev = s.sync2[1];
    next_s.xout      = cfg.ctrl.secondary_osc_enable & ~s.sync2[1];
    if (!cfg.ctrl.secondary_osc_enable) begin
      next_s.osc_cnt = 11'h000;
      next_s.ready   = 1'b0;
    end else if (s.sync2[1] && !s.xtal_prev && !s.ready) begin
      next_s.osc_cnt = s.osc_cnt + 11'h001;
      next_s.ready   = (s.osc_cnt == (gst_pkg::GST_OSC_STABLE - 11'h001));
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      s       <= '0;
      s.count <= gst_pkg::GST_CNT_RST;
    end else begin
      s <= next_s;
    end
  end

  assign stat.count               = s.count;
  assign stat.overflow            = s.ovf;
  assign stat.secondary_osc_ready = s.ready;
  assign crystal_output_pin       = s.xout;

endmodule

`default_nettype wire

// ===== core/gst_top.sv
// The placing of the registers and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none

module gst_top (
  input  wire logic        mclk,
  input  wire logic        rstn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        sleep,
  input  wire logic [2:0]  count_clock,
  input  wire logic [2:0]  crystal_input_pin,
  output logic [2:0]       crystal_output_pin,
  input  wire logic [2:0]  gate_signal,
  input  wire logic [2:0]  gate_int_src,
  output logic             irq,
  output logic             wake
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic                   awready;
    logic                   wready;
    logic                   aw_got;
    logic                   w_got;
    logic [7:0]             awaddr;
    logic [7:0]             wdata;
    logic                   wstrb0;
    logic                   bvalid;
    logic [1:0]             bresp;
    logic                   arready;
    logic                   rvalid;
    logic [31:0]            rdata;
    logic [1:0]             rresp;
    gst_pkg::gst_cfg_t [2:0] cfg;
    logic [2:0]             wr_lo;
    logic [2:0]             wr_hi;
    logic [7:0]             wr_data;
    logic [2:0]             int_status;
    logic [2:0]             int_mask;
    logic [1:0]             int_div;
    logic                   int_tick;
    logic                   irq;
    logic                   wake;
  } gst_top_state_t;

  gst_top_state_t s;
  gst_top_state_t next_s;

  gst_pkg::gst_stat_t [2:0] stat;

  // ----------------------------------------------------------------
  // timer instances
  // ----------------------------------------------------------------
  for (genvar i = 0; i < gst_pkg::GST_NUM_TMR; i++) begin : g_tmr
    gst_timer u_tmr (
      .mclk               (mclk),
      .rstn               (rstn),
      .cfg                (s.cfg[i]),
      .wr_lo              (s.wr_lo[i]),
      .wr_hi              (s.wr_hi[i]),
      .wr_data            (s.wr_data),
      .int_tick           (s.int_tick),
      .sleep              (sleep),
      .count_clock        (count_clock[i]),
      .crystal_input_pin  (crystal_input_pin[i]),
      .gate_signal        (gate_signal[i]),
      .gate_int_src       (gate_int_src),
      .stat               (stat[i]),
      .crystal_output_pin (crystal_output_pin[i])
    );
  end

  // ----------------------------------------------------------------
  // register read decode
  // ----------------------------------------------------------------
  function automatic logic [32:0] rd_decode(
    input logic [7:0]               addr,
    input gst_top_state_t           st,
    input gst_pkg::gst_stat_t [2:0] sv
  );
    logic [32:0] r;
    logic [7:0]  base;
    r = {1'b1, 32'h0000_0000};
    for (int i = 0; i < gst_pkg::GST_NUM_TMR; i++) begin
      base = gst_pkg::GST_TMR_STRIDE * 8'(i);
      if (addr == base + gst_pkg::GST_OFF_CNT_LO) begin
        r = {1'b0, 24'h000000, sv[i].count[7:0]};
      end
      if (addr == base + gst_pkg::GST_OFF_CNT_HI) begin
        r = {1'b0, 24'h000000, sv[i].count[15:8]};
      end
      if (addr == base + gst_pkg::GST_OFF_CTRL) begin
        r = {1'b0, 24'h000000, st.cfg[i].ctrl};
      end
      if (addr == base + gst_pkg::GST_OFF_GATE) begin
        r = {1'b0, 24'h000000, st.cfg[i].gate};
      end
    end
    if (addr == gst_pkg::GST_OFF_INT_STAT) begin
      r = {1'b0, 29'h0000_0000, st.int_status};
    end
    if (addr == gst_pkg::GST_OFF_INT_MASK) begin
      r = {1'b0, 29'h0000_0000, st.int_mask};
    end
    if (addr == gst_pkg::GST_OFF_OSC_STAT) begin
      r = {1'b0, 29'h0000_0000, sv[2].secondary_osc_ready,
           sv[1].secondary_osc_ready, sv[0].secondary_osc_ready};
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic        aw_have;
    logic        w_have;
    logic [7:0]  waddr;
    logic [7:0]  wbyte;
    logic        wen;
    logic        hit;
    logic [7:0]  base;
    logic [2:0]  clr;
    logic [32:0] rd;
    aw_have = 1'b0;
    w_have  = 1'b0;
    waddr   = 8'h00;
    wbyte   = 8'h00;
    wen     = 1'b0;
    hit     = 1'b0;
    base    = 8'h00;
    clr     = 3'h0;
    rd      = 33'h0_0000_0000;
    next_s       = s;
    next_s.wr_lo = 3'h0;
    next_s.wr_hi = 3'h0;

    // internal count clock: one tick every fourth cycle
    next_s.int_div  = s.int_div + 2'h1;
    next_s.int_tick = (s.int_div == gst_pkg::GST_INT_DIV_LAST);

    // write address and data are taken in either order
    if (s_axi_awvalid && s.awready) begin
      next_s.aw_got = 1'b1;
      next_s.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s.wready) begin
      next_s.w_got  = 1'b1;
      next_s.wdata  = s_axi_wdata[7:0];
      next_s.wstrb0 = s_axi_wstrb[0];
    end
    aw_have = next_s.aw_got;
    w_have  = next_s.w_got;
    waddr   = {next_s.awaddr[7:2], 2'b00};
    wbyte   = next_s.wdata;
    wen     = next_s.wstrb0;

    if (aw_have && w_have && !s.bvalid) begin
      next_s.aw_got = 1'b0;
      next_s.w_got  = 1'b0;
      next_s.bvalid = 1'b1;
      hit           = 1'b0;
      for (int i = 0; i < gst_pkg::GST_NUM_TMR; i++) begin
        base = gst_pkg::GST_TMR_STRIDE * 8'(i);
        if (waddr == base + gst_pkg::GST_OFF_CNT_LO) begin
          hit             = 1'b1;
          next_s.wr_lo[i] = wen;
        end
        if (waddr == base + gst_pkg::GST_OFF_CNT_HI) begin
          hit             = 1'b1;
          next_s.wr_hi[i] = wen;
        end
        if (waddr == base + gst_pkg::GST_OFF_CTRL) begin
          hit = 1'b1;
          if (wen) begin
            next_s.cfg[i].ctrl          = wbyte;
            next_s.cfg[i].ctrl.reserved = 2'h0;
          end
        end
        if (waddr == base + gst_pkg::GST_OFF_GATE) begin
          hit = 1'b1;
          if (wen) begin
            next_s.cfg[i].gate          = wbyte;
            next_s.cfg[i].gate.reserved = 4'h0;
          end
        end
      end
      if (waddr == gst_pkg::GST_OFF_INT_STAT) begin
        hit = 1'b1;
        clr = wen ? wbyte[2:0] : 3'h0;
      end
      if (waddr == gst_pkg::GST_OFF_INT_MASK) begin
        hit = 1'b1;
        if (wen) begin
          next_s.int_mask = wbyte[2:0];
        end
      end
      if (waddr == gst_pkg::GST_OFF_OSC_STAT) begin
        hit = 1'b1;
      end
      next_s.wr_data = wbyte;
      next_s.bresp   = hit ? gst_pkg::GST_RESP_OKAY : gst_pkg::GST_RESP_SLVERR;
    end else if (s.bvalid && s_axi_bready) begin
      next_s.bvalid = 1'b0;
    end
    next_s.awready = ~next_s.aw_got & ~next_s.bvalid;
    next_s.wready  = ~next_s.w_got & ~next_s.bvalid;

    // read channel
    if (s_axi_arvalid && s.arready) begin
      rd            = rd_decode({s_axi_araddr[7:2], 2'b00}, s, stat);
      next_s.rvalid = 1'b1;
      next_s.rdata  = rd[31:0];
      next_s.rresp  = rd[32] ? gst_pkg::GST_RESP_SLVERR : gst_pkg::GST_RESP_OKAY;
    end else if (s.rvalid && s_axi_rready) begin
      next_s.rvalid = 1'b0;
    end
    next_s.arready = ~next_s.rvalid;

    // sticky overflow flags: a set in the clearing cycle wins
    for (int i = 0; i < gst_pkg::GST_NUM_TMR; i++) begin
      next_s.int_status[i] = (s.int_status[i] & ~clr[i]) | stat[i].overflow;
    end
    next_s.irq  = |(next_s.int_status & next_s.int_mask);
    next_s.wake = sleep & (|(next_s.int_status & next_s.int_mask));
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      s <= '0;
      for (int i = 0; i < gst_pkg::GST_NUM_TMR; i++) begin
        s.cfg[i].ctrl <= gst_pkg::GST_CTRL_RST;
        s.cfg[i].gate <= gst_pkg::GST_GATE_RST;
      end
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign s_axi_awready = s.awready;
  assign s_axi_wready  = s.wready;
  assign s_axi_bvalid  = s.bvalid;
  assign s_axi_bresp   = s.bresp;
  assign s_axi_arready = s.arready;
  assign s_axi_rvalid  = s.rvalid;
  assign s_axi_rdata   = s.rdata;
  assign s_axi_rresp   = s.rresp;
  assign irq           = s.irq;
  assign wake          = s.wake;

endmodule

`default_nettype wire

// ===== tb/gst_assertions.sv
`timescale 1ns/100ps
`default_nettype none
// ------------------------------------------------------------
// bus and interrupt checks
// ------------------------------------------------------------
module gst_checker (
  input wire logic        mclk,
  input wire logic        rstn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        sleep,
  input wire logic [2:0]  crystal_output_pin,
  input wire logic        irq,
  input wire logic        wake
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rstn);

  AST_WR_ANSWER: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
    else $error("write response late");
  AST_WR_HOLD: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  AST_WR_REOPEN: assert property (
    s_axi_bvalid && s_axi_bready |=> s_axi_awready && s_axi_wready)
    else $error("write channel reopen timing");
  AST_RD_ANSWER: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  AST_RD_HOLD: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data unstable");
  AST_RD_BYTE: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("read data upper bits set");
  AST_RD_REOPEN: assert property (
    s_axi_rvalid && s_axi_rready |=> s_axi_arready)
    else $error("read channel reopen timing");
  AST_IRQ_STICKY: assert property (
    irq && !s_axi_bvalid && !(s_axi_awvalid && s_axi_awready) |=> irq)
    else $error("interrupt dropped without a write");
  AST_WAKE_IRQ: assert property (
    wake |-> irq && $past(sleep))
    else $error("wake without asleep interrupt");
  AST_RESET_QUIET: assert property (
    @(posedge mclk) disable iff (1'b0)
    !rstn |=> !irq && !wake && crystal_output_pin == 3'h0 && !s_axi_bvalid && !s_axi_rvalid)
    else $error("outputs active after reset");
endmodule

bind gst_top gst_checker gst_checker_inst (
  .mclk(mclk), .rstn(rstn), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .sleep(sleep), .crystal_output_pin(crystal_output_pin),
  .irq(irq), .wake(wake)
);
`default_nettype wire

// ===== tb/gst_partner.sv
`timescale 1ns/100ps
`default_nettype none
// ------------------------------------------------------------
// clock pins, crystal and gate sources
// ------------------------------------------------------------
module gst_partner (
  input  wire logic       mclk,
  input  wire logic       rstn,
  input  wire logic       start,
  input  wire logic [2:0] sel,
  input  var  int         n_edges,
  input  wire logic [2:0] gate_lvl,
  input  wire logic [2:0] crystal_output_pin,
  output logic [2:0]      count_clock,
  output logic [2:0]      crystal_input_pin,
  output logic [2:0]      gate_signal,
  output logic            busy
);
  int         left;
  int         ph;
  logic [2:0] xd;
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      left <= 0;
      ph <= 0;
      busy <= 1'b0;
      xd <= 3'h0;
      count_clock <= 3'h0;
      crystal_input_pin <= 3'h0;
      gate_signal <= 3'h0;
    end else begin
      xd <= crystal_output_pin;
      crystal_input_pin <= xd;
      gate_signal <= gate_lvl;
      if (start) begin
        left <= n_edges;
        ph <= 0;
        busy <= 1'b1;
      end else if (busy) begin
        ph <= (ph == 9) ? 0 : ph + 1;
        if (ph == 4) count_clock <= sel;
        if (ph == 9) begin
          count_clock <= 3'h0;
          left <= left - 1;
          busy <= (left > 1);
        end
      end
    end
  end
endmodule
`default_nettype wire

// ===== tb/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic        mclk = 1'b0;
  logic        rstn = 1'b0;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  logic        sleep = 1'b0;
  logic        start = 1'b0;
  logic [2:0]  sel = 3'h0;
  int          n_edges = 0;
  logic [2:0]  gate_lvl = 3'h0;
  logic [2:0]  gate_int_src = 3'h0;
  wire logic   awready, wready, bvalid, arready, rvalid, irq, wake, busy;
  wire logic [1:0]  bresp, rresp;
  wire logic [31:0] rdata;
  wire logic [2:0]  cclk, xin, xout, gsig;
  int          n_fail = 0;
  int          cmp_count = 0;
  localparam logic [1:0] OK = gst_pkg::GST_RESP_OKAY;

  always #4 mclk = ~mclk;

  gst_top gst_top_inst (.mclk(mclk), .rstn(rstn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .sleep(sleep), .count_clock(cclk), .crystal_input_pin(xin),
    .crystal_output_pin(xout), .gate_signal(gsig), .gate_int_src(gate_int_src), .irq(irq),
    .wake(wake));
  gst_partner gst_partner_inst (.mclk(mclk), .rstn(rstn), .start(start), .sel(sel),
    .n_edges(n_edges), .gate_lvl(gate_lvl), .crystal_output_pin(xout), .count_clock(cclk),
    .crystal_input_pin(xin), .gate_signal(gsig), .busy(busy));

  // ------------------------------------------------------------
  // bus tasks and checks
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      n_fail++;
      $display("[ERR] t=%0t seen %h exp %h", $time, s, e);
    end
  endtask

  task automatic test_done;
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    logic       pa, pw, ta, tw, tb;
    logic [1:0] r;
    pa = 1'b1;
    pw = 1'b1;
    tb = 1'b0;
    @(posedge mclk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!tb) begin
      @(negedge mclk);
      tb = !pa && !pw && bvalid;
      ta = pa && awready;
      tw = pw && wready;
      r = bresp;
      @(posedge mclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      pa = pa && !ta;
      pw = pw && !tw;
    end
    bready <= 1'b0;
    chk(32'(r), 32'(er));
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic tk, tr, g;
    tk = 1'b0;
    tr = 1'b0;
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!tr) begin
      @(negedge mclk);
      tr = tk && rvalid;
      g = !tk && arready;
      d = rdata;
      r = rresp;
      @(posedge mclk);
      if (g) arvalid <= 1'b0;
      tk = tk || g;
    end
    rready <= 1'b0;
  endtask

  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    chk(d, {24'h0, e});
    chk(32'(r), 32'(OK));
  endtask

  task automatic rd16(input logic [7:0] b, output logic [15:0] c);
    logic [31:0] lo, hi;
    logic [1:0]  r;
    rd(b, lo, r);
    rd(b + 8'h04, hi, r);
    c = {hi[7:0], lo[7:0]};
  endtask

  task automatic pul(input logic [2:0] s, input int n);
    @(posedge mclk);
    sel <= s;
    n_edges <= n;
    start <= 1'b1;
    @(posedge mclk);
    start <= 1'b0;
    do @(negedge mclk); while (busy);
    repeat (8) @(posedge mclk);
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  initial begin
    logic [15:0] c, e;
    logic [31:0] d;
    logic [1:0]  r;
    logic [3:0]  v;
    repeat (4) @(posedge mclk);
    rstn <= 1'b1;
    repeat (2) @(posedge mclk);
    for (int t = 0; t < 4; t++) rc(8'(t * 16), 8'h00);
    for (int t = 0; t < 3; t++) begin
      rc(8'(t * 16 + 8), 8'h00);
      rc(8'(t * 16 + 12), 8'h00);
      wr(8'(t * 16), 8'(8'h5a + t), OK);
      wr(8'(t * 16 + 4), 8'(8'ha5 - t), OK);
      rc(8'(t * 16), 8'(8'h5a + t));
      rc(8'(t * 16 + 4), 8'(8'ha5 - t));
      wr(8'(t * 16 + 8), 8'hf6, OK);
      rc(8'(t * 16 + 8), 8'h36);
      wr(8'(t * 16 + 8), 8'h00, OK);
      wr(8'(t * 16 + 12), 8'hff, OK);
      rc(8'(t * 16 + 12), 8'hc3);
    end
    wr(8'h3c, 8'h11, gst_pkg::GST_RESP_SLVERR);
    rd(8'h3c, d, r);
    chk(d, 32'h0);
    chk(32'(r), 32'(gst_pkg::GST_RESP_SLVERR));
    wr(8'h38, 8'hff, OK);
    rc(8'h38, 8'h00);
    for (int p = 0; p < 4; p++) begin
      wr(8'h00, 8'h00, OK);
      wr(8'h04, 8'h00, OK);
      wr(8'h0c, 8'h00, OK);
      wr(8'h08, 8'(8'h01 | (p << 4)), OK);
      repeat (256) @(posedge mclk);
      wr(8'h08, 8'h00, OK);
      rd16(8'h00, c);
      e = 16'(64 >> p);
      chk(32'((c + 3 >= e) && (c <= e + 3)), 32'h1);
    end
    wr(8'h20, 8'h00, OK);
    wr(8'h24, 8'h00, OK);
    wr(8'h28, 8'h09, OK);
    e = 16'h0;
    for (int s = 0; s < 4; s++) begin
      for (int pol = 0; pol < 2; pol++) begin
        v = (pol == 1) ? (4'h1 << s) : ~(4'h1 << s);
        wr(8'h2c, 8'(8'h80 | (pol << 6) | s), OK);
        for (int k = 0; k < 2; k++) begin
          @(posedge mclk);
          gate_lvl <= {3{v[0] ^ (k == 0)}};
          gate_int_src <= v[3:1] ^ {3{k == 0}};
          pul(3'b100, 3);
          e = e + 16'(3 * k);
          rd16(8'h20, c);
          chk(32'(c), 32'(e));
        end
      end
    end
    @(posedge mclk);
    gate_lvl <= 3'h0;
    wr(8'h2c, 8'h40, OK);
    pul(3'b100, 3);
    rd16(8'h20, c);
    chk(32'(c), 32'(e + 16'h3));
    wr(8'h28, 8'h39, OK);
    pul(3'b100, 4);
    wr(8'h20, 8'h00, OK);
    wr(8'h24, 8'h00, OK);
    pul(3'b100, 7);
    rd16(8'h20, c);
    chk(32'(c), 32'h0);
    pul(3'b100, 1);
    rd16(8'h20, c);
    chk(32'(c), 32'h1);
    wr(8'h34, 8'h02, OK);
    wr(8'h10, 8'hfe, OK);
    wr(8'h14, 8'hff, OK);
    wr(8'h18, 8'h0b, OK);
    @(posedge mclk);
    sleep <= 1'b1;
    pul(3'b010, 3);
    @(negedge mclk);
    chk(32'(irq), 32'h1);
    chk(32'(wake), 32'h1);
    @(posedge mclk);
    sleep <= 1'b0;
    rd16(8'h10, c);
    chk(32'(c), 32'h1);
    rc(8'h30, 8'h02);
    wr(8'h34, 8'h00, OK);
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    chk(32'(irq), 32'h0);
    rc(8'h30, 8'h02);
    wr(8'h30, 8'h02, OK);
    rc(8'h30, 8'h00);
    wr(8'h00, 8'h00, OK);
    wr(8'h04, 8'hfc, OK);
    wr(8'h34, 8'h01, OK);
    wr(8'h08, 8'h0d, OK);
    do @(negedge mclk); while (!irq);
    repeat (100) @(posedge mclk);
    rc(8'h38, 8'h01);
    rc(8'h30, 8'h01);
    wr(8'h08, 8'h00, OK);
    repeat (8) @(posedge mclk);
    rc(8'h38, 8'h00);
    chk(32'(xout), 32'h0);
    test_done();
  end

  initial begin
    repeat (60000) @(posedge mclk);
    n_fail++;
    test_done();
  end
endmodule
`default_nettype wire
